// file: pkg/eerc_params.svh
// constants for the exception entry and return controller
`ifndef EERC_PARAMS_SVH
`define EERC_PARAMS_SVH
`define EERC_NIRQ 8
`define EERC_NEXC 11
`define EERC_KEYW 7
`define EERC_SELW 12
`define EERC_FRAME_BYTES 32'h00000020
`define EERC_PAD_BYTES 32'h00000004
`define EERC_WORD_BYTES 32'h00000004
`define EERC_PC_WORD 3'h6
`define EERC_PSR_WORD 3'h7
`define EERC_PAD_BIT 9
`define EERC_OFS_CTRL 6'h00
`define EERC_OFS_PRIO 6'h01
`define EERC_OFS_PEND 6'h02
`define EERC_OFS_STAT 6'h03
`define EERC_OFS_TOKEN 6'h04
`define EERC_CTRL_SPLIT_LSB 0
`define EERC_CTRL_ALIGN 4
`define EERC_CTRL_PMASK 8
`define EERC_CTRL_FMASK 9
`define EERC_CTRL_BASE_PRIORITY_LIMIT_LSB 16
`define EERC_CTRL_IMPL 32'h00070313
`define EERC_CTRL_RST 32'h00000010
`define EERC_PRIO_IMPL 32'h07ffffff
`define EERC_STAT_THREAD 16
`define EERC_STAT_ST_LSB 20
`define EERC_STAT_CUR_LSB 24
`define EERC_TOK_HIGH 28'hfffffff
`define EERC_TOK_HANDLER 4'h1
`define EERC_TOK_THR_MAIN 4'h9
`define EERC_TOK_THR_PROC 4'hd
`define EERC_RANK_HF 4'h1
`define EERC_RANK_CFG 4'h2
`define EERC_RANK_THREAD 4'ha
`define EERC_VTAB_BASE 32'h00000000
`define EERC_VEC_NMI 8'h02
`define EERC_VEC_HF 8'h03
`define EERC_VEC_FAULT 8'h06
`define EERC_VEC_IRQ_OFS 8'h0d
`endif

// file: pkg/eerc_pkg.sv
// types for the exception entry and return controller
`include "eerc_params.svh"
package eerc_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_STACK, ST_VEC, ST_START, ST_UNSTACK} eerc_state_t;
  typedef struct packed {
    eerc_state_t st;
    logic [31:0] ctrl, prio, tok, retpc, base, maddr, wdata;
    logic [31:0] vaddr, haddr, spdata, pcdata, dat;
    logic [`EERC_NEXC-1:0] pend, act;
    logic [`EERC_NIRQ-1:0] is1, is2, is3;
    logic ns1, ns2, ns3, thread, spsel, memreq, memwe;
    logic vreq, vagain, vdone, branch, lrwe, spwe, pcld, ack;
    logic [3:0] cur;
    logic [2:0] idx;
  } eerc_regs_t;
endpackage

// file: rtl/eerc_core.sv
// exception entry, return and priority sequencing controller
// Functional notes
// - priority splits into group and subpriority
// - preemption compares group priority only
// - ties: lower subpriority, then lower number
// - pending exception on return tail-chains, no pop
// - late higher arrival refetches vector, stacking continues
// - late arrival accepted until first handler execute
// - entry needs thread mode or higher priority
// - masked exceptions stay pending, not taken
// - fresh entry pushes eight-word frame
// - stack pointer gets aligned frame base
// - frame holds return address, restored on return
// - vector fetch runs in parallel with stacking
// - entry writes return token to link register
// - pending becomes active when handler starts
// - late arrival leaves earlier pending untouched
// - token loaded into pc in handler returns
// - token upper bits all ones
// - token f1 returns handler mode, main stack
// - token f9 thread main; all but f1, f9, fd reserved
// - token fd returns thread mode, process stack
// - return without pending pops the frame
// - bus, instruction, state, region errors raise fault
// - lower value wins; fixed ones above configurable
// - configurable priorities are three bits
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
module eerc_core (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic [`EERC_NIRQ-1:0] irq_i, // interrupt pins
  input wire logic nmi_i, // non-maskable pin
  input wire logic ibus_err_i, // fetch bus error
  input wire logic dbus_err_i, // data bus error
  input wire logic undef_i, // undefined instruction
  input wire logic inv_state_i, // invalid state change
  input wire logic xn_exec_i, // non_executable_region fetch
  input wire logic prot_viol_i, // protection_unit violation
  input wire logic [31:0] next_pc_i, // next instruction address
  input wire logic [31:0] msp_i, // main_stack_pointer
  input wire logic [31:0] psp_i, // process_stack_pointer
  input wire logic use_psp_i, // thread runs on process stack
  input wire logic first_exec_i, // handler first instr executes
  input wire logic ret_i, // program_counter load of token
  input wire logic [31:0] ret_val_i, // value loaded
  output logic mem_req_o, // frame access request
  output logic mem_we_o, // frame write
  output logic [31:0] mem_addr_o, // frame word address
  output logic [2:0] mem_idx_o, // frame word index
  output logic [31:0] mem_wdata_o, // pc and pad words
  input wire logic mem_ack_i, // frame access done
  input wire logic mem_err_i, // frame access error
  input wire logic [31:0] mem_rdata_i, // frame read data
  output logic vec_req_o, // vector fetch request
  output logic [31:0] vec_addr_o, // vector address
  input wire logic vec_ack_i, // vector fetch done
  input wire logic vec_err_i, // vector bus error
  input wire logic [31:0] vec_data_i, // handler address
  output logic branch_o, // branch to handler pulse
  output logic [31:0] branch_addr_o, // handler address
  output logic lr_we_o, // link_register write pulse
  output logic [31:0] lr_data_o, // return token
  output logic sp_we_o, // stack pointer write pulse
  output logic sp_psp_o, // 1 process, 0 main
  output logic [31:0] sp_data_o, // new stack pointer
  output logic pc_load_o, // restore pc pulse
  output logic [31:0] pc_data_o, // restored return address
  output logic handler_mode_o // 1 in handler mode
);
  localparam eerc_pkg::eerc_regs_t RST = '{st: eerc_pkg::ST_RUN, thread: 1'b1,
    ctrl: `EERC_CTRL_RST, default: '0};

  // ----------------------------------------
  // priority helpers
  // ----------------------------------------
  // group rank of a configurable priority
  function automatic logic [3:0] grp(input logic [2:0] p, input logic [1:0] s);
    grp = {1'b0, p & (3'h7 << s)} + `EERC_RANK_CFG;
  endfunction

  // best of a set: lowest key, then number
  function automatic logic [`EERC_SELW-1:0] pick(
      input logic [`EERC_NEXC-1:0][`EERC_KEYW-1:0] k,
      input logic [`EERC_NEXC-1:0] m);
    logic [`EERC_SELW-1:0] b;
    b = '0;
    for (int i = 0; i < `EERC_NEXC; i++) begin
      if (m[i] && (!b[11] || k[i] < b[6:0])) begin
        b = {1'b1, 4'(i), k[i]};
      end
    end
    pick = b;
  endfunction

  // vector address of an exception
  function automatic logic [31:0] vaddr(input logic [3:0] e);
    logic [7:0] v;
    v = (e == 4'h0) ? `EERC_VEC_NMI : (e == 4'h1) ? `EERC_VEC_HF :
        (e == 4'h2) ? `EERC_VEC_FAULT : ({4'h0, e} + `EERC_VEC_IRQ_OFS);
    vaddr = `EERC_VTAB_BASE + {22'h0, v, 2'b00};
  endfunction

  eerc_pkg::eerc_regs_t r;
  eerc_pkg::eerc_regs_t n;
  logic [`EERC_NEXC-1:0][`EERC_KEYW-1:0] key;
  logic [1:0] split;
  logic [`EERC_SELW-1:0] pb, ab, ab2;
  logic [3:0] mlim, arank, arank2, lim, lim2, crank;
  logic [`EERC_NEXC-1:0] one_a, one_c, act2, setp, clrp, sw_set;
  logic take, take2, late, tok_ok, bad_tok, wb_req, entry_st;
  logic [31:0] wm, sp_cur, nxt_addr;
  logic [3:0] tok_low;

  // ----------------------------------------
  // priority keys per exception
  // ----------------------------------------
  assign split = r.ctrl[`EERC_CTRL_SPLIT_LSB +: 2];
  for (genvar g = 0; g < `EERC_NEXC; g++) begin : g_key
    if (g < 2) begin : g_fix
      assign key[g] = {4'(g), 3'h0};
    end else begin : g_cfg
      logic [2:0] p;
      assign p = r.prio[3*(g-2) +: 3];
      assign key[g] = {grp(p, split), p & ~(3'h7 << split)};
    end
  end

  // mask limit from the three masks
  always_comb begin
    mlim = `EERC_RANK_THREAD;
    if (r.ctrl[`EERC_CTRL_BASE_PRIORITY_LIMIT_LSB +: 3] != 3'h0) begin
      mlim = grp(r.ctrl[`EERC_CTRL_BASE_PRIORITY_LIMIT_LSB +: 3], split);
    end
    if (r.ctrl[`EERC_CTRL_PMASK]) begin
      mlim = `EERC_RANK_CFG;
    end
    if (r.ctrl[`EERC_CTRL_FMASK]) begin
      mlim = `EERC_RANK_HF;
    end
  end

  // best pending, running and next running
  assign pb = pick(key, r.pend);
  assign ab = pick(key, r.act);
  assign one_a = {{(`EERC_NEXC-1){1'b0}}, 1'b1} << ab[10:7];
  assign one_c = {{(`EERC_NEXC-1){1'b0}}, 1'b1} << r.cur;
  assign act2 = r.act & ~one_a;
  assign ab2 = pick(key, act2);
  assign arank = ab[11] ? ab[6:3] : `EERC_RANK_THREAD;
  assign arank2 = ab2[11] ? ab2[6:3] : `EERC_RANK_THREAD;
  assign lim = (arank < mlim) ? arank : mlim;
  assign lim2 = (arank2 < mlim) ? arank2 : mlim;
  assign crank = key[r.cur][6:3];
  // entry needs rank above limit and running
  assign take = pb[11] && (pb[6:3] < lim);
  assign take2 = pb[11] && (pb[6:3] < lim2);
  assign entry_st = (r.st == eerc_pkg::ST_STACK) || (r.st == eerc_pkg::ST_VEC) ||
                    (r.st == eerc_pkg::ST_START);
  // late window shuts at first handler execute
  assign late = entry_st && pb[11] && (pb[6:3] < mlim) && (pb[6:3] < crank) &&
                !((r.st == eerc_pkg::ST_START) && first_exec_i);

  // ----------------------------------------
  // return token decode
  // ----------------------------------------
  assign tok_low = ret_val_i[3:0];
  assign tok_ok = (ret_val_i[31:4] == `EERC_TOK_HIGH) &&
                  ((tok_low == `EERC_TOK_HANDLER) ||
                   (tok_low == `EERC_TOK_THR_MAIN) ||
                   (tok_low == `EERC_TOK_THR_PROC));
  assign bad_tok = (r.st == eerc_pkg::ST_RUN) && ret_i && !r.thread && !tok_ok;

  // ----------------------------------------
  // bus decode and pending sources
  // ----------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign sw_set = (wb_req && wb_we_i && wb_adr_i[7:2] == `EERC_OFS_PEND) ?
                  (wb_dat_i[`EERC_NEXC-1:0] & wm[`EERC_NEXC-1:0]) : '0;
  // pin edges, faults and software requests
  always_comb begin
    setp = sw_set;
    setp[0] = setp[0] | (r.ns2 & ~r.ns3);
    setp[1] = setp[1] | (r.vreq & vec_ack_i & vec_err_i);
    setp[2] = setp[2] | ibus_err_i | dbus_err_i | undef_i | inv_state_i | xn_exec_i |
              prot_viol_i | bad_tok | (r.memreq & mem_ack_i & mem_err_i);
    setp[`EERC_NEXC-1:3] = setp[`EERC_NEXC-1:3] | (r.is2 & ~r.is3);
  end
  // taken exception leaves pending, unless late
  assign clrp = ((r.st == eerc_pkg::ST_START) && first_exec_i && !late) ? one_c : '0;

  // stack in use at entry
  assign sp_cur = (r.thread && use_psp_i) ? psp_i : msp_i;
  assign nxt_addr = r.maddr + `EERC_WORD_BYTES;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.branch = 1'b0;
    n.lrwe = 1'b0;
    n.spwe = 1'b0;
    n.pcld = 1'b0;
    n.ack = wb_req;
    n.is1 = irq_i;
    n.is2 = r.is1;
    n.is3 = r.is2;
    n.ns1 = nmi_i;
    n.ns2 = r.ns1;
    n.ns3 = r.ns2;
    n.pend = (r.pend & ~clrp) | setp;
    // register writes with byte enables
    if (wb_req && wb_we_i) begin
      if (wb_adr_i[7:2] == `EERC_OFS_CTRL) begin
        n.ctrl = (r.ctrl & ~wm) | (wb_dat_i & wm & `EERC_CTRL_IMPL);
      end
      if (wb_adr_i[7:2] == `EERC_OFS_PRIO) begin
        n.prio = (r.prio & ~wm) | (wb_dat_i & wm & `EERC_PRIO_IMPL);
      end
    end
    // register reads, unmapped read zero
    if (wb_req) begin
      unique case (wb_adr_i[7:2])
        `EERC_OFS_CTRL: n.dat = r.ctrl;
        `EERC_OFS_PRIO: n.dat = r.prio;
        `EERC_OFS_PEND: n.dat = {21'h0, r.pend};
        `EERC_OFS_STAT: begin
          n.dat = {21'h0, r.act};
          n.dat[`EERC_STAT_THREAD] = r.thread;
          n.dat[`EERC_STAT_ST_LSB +: 3] = r.st;
          n.dat[`EERC_STAT_CUR_LSB +: 4] = r.cur;
        end
        `EERC_OFS_TOKEN: n.dat = r.tok;
        default: n.dat = 32'h0;
      endcase
    end
    // vector fetch, refetch after late arrival
    if (r.vreq && vec_ack_i) begin
      n.vagain = 1'b0;
      if (r.vagain) begin
        n.vaddr = vaddr(r.cur);
      end else begin
        n.vreq = 1'b0;
        n.vdone = 1'b1;
        n.haddr = vec_data_i;
      end
    end
    // late arrival switches target, stacking untouched
    if (late) begin
      n.cur = pb[10:7];
      n.vdone = 1'b0;
      if (r.vreq) begin
        n.vagain = 1'b1;
      end else begin
        n.vreq = 1'b1;
        n.vaddr = vaddr(pb[10:7]);
      end
    end
    unique case (r.st)
      eerc_pkg::ST_RUN: begin
        if (ret_i && !r.thread && tok_ok) begin
          n.act = act2;
          n.tok = ret_val_i;
          n.thread = ret_val_i[3];
          if (take2) begin
            n.cur = pb[10:7];
            n.vreq = 1'b1;
            n.vdone = 1'b0;
            n.vaddr = vaddr(pb[10:7]);
            n.st = eerc_pkg::ST_VEC;
          end else begin
            n.spsel = ret_val_i[2];
            n.base = ret_val_i[2] ? psp_i : msp_i;
            n.maddr = ret_val_i[2] ? psp_i : msp_i;
            n.idx = 3'h0;
            n.memreq = 1'b1;
            n.memwe = 1'b0;
            n.st = eerc_pkg::ST_UNSTACK;
          end
        end else if (take) begin
          n.cur = pb[10:7];
          n.tok = {`EERC_TOK_HIGH, !r.thread ? `EERC_TOK_HANDLER :
                   use_psp_i ? `EERC_TOK_THR_PROC : `EERC_TOK_THR_MAIN};
          n.retpc = next_pc_i;
          n.spsel = r.thread && use_psp_i;
          if (r.ctrl[`EERC_CTRL_ALIGN] && sp_cur[2]) begin
            n.base = sp_cur - `EERC_FRAME_BYTES - `EERC_PAD_BYTES;
          end else begin
            n.base = sp_cur - `EERC_FRAME_BYTES;
          end
          n.maddr = n.base;
          n.idx = 3'h0;
          n.wdata = 32'h0;
          n.memreq = 1'b1;
          n.memwe = 1'b1;
          n.vreq = 1'b1;
          n.vagain = 1'b0;
          n.vdone = 1'b0;
          n.vaddr = vaddr(pb[10:7]);
          n.st = eerc_pkg::ST_STACK;
        end
      end
      eerc_pkg::ST_STACK: begin
        if (mem_ack_i) begin
          if (r.idx == `EERC_PSR_WORD) begin
            n.memreq = 1'b0;
            n.memwe = 1'b0;
            n.spwe = 1'b1;
            n.spdata = r.base;
            n.st = eerc_pkg::ST_VEC;
          end else begin
            n.idx = r.idx + 3'h1;
            n.maddr = nxt_addr;
            n.wdata = 32'h0;
            if (r.idx + 3'h1 == `EERC_PC_WORD) begin
              n.wdata = r.retpc;
            end
            if (r.idx + 3'h1 == `EERC_PSR_WORD) begin
              n.wdata[`EERC_PAD_BIT] = (r.base != sp_cur - `EERC_FRAME_BYTES);
            end
          end
        end
      end
      eerc_pkg::ST_VEC: begin
        if (r.vdone && !r.vreq && !late) begin
          n.branch = 1'b1;
          n.lrwe = 1'b1;
          n.thread = 1'b0;
          n.st = eerc_pkg::ST_START;
        end
      end
      eerc_pkg::ST_START: begin
        if (late) begin
          n.st = eerc_pkg::ST_VEC;
        end else if (first_exec_i) begin
          n.act = r.act | one_c;
          n.st = eerc_pkg::ST_RUN;
        end
      end
      eerc_pkg::ST_UNSTACK: begin
        if (mem_ack_i) begin
          if (r.idx == `EERC_PC_WORD) begin
            n.pcdata = mem_rdata_i;
          end
          if (r.idx == `EERC_PSR_WORD) begin
            n.memreq = 1'b0;
            n.spwe = 1'b1;
            n.spdata = r.base + `EERC_FRAME_BYTES +
                       (mem_rdata_i[`EERC_PAD_BIT] ? `EERC_PAD_BYTES : 32'h0);
            n.pcld = 1'b1;
            n.st = eerc_pkg::ST_RUN;
          end else begin
            n.idx = r.idx + 3'h1;
            n.maddr = nxt_addr;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign mem_req_o = r.memreq;
  assign mem_we_o = r.memwe;
  assign mem_addr_o = r.maddr;
  assign mem_idx_o = r.idx;
  assign mem_wdata_o = r.wdata;
  assign vec_req_o = r.vreq;
  assign vec_addr_o = r.vaddr;
  assign branch_o = r.branch;
  assign branch_addr_o = r.haddr;
  assign lr_we_o = r.lrwe;
  assign lr_data_o = r.tok;
  assign sp_we_o = r.spwe;
  assign sp_psp_o = r.spsel;
  assign sp_data_o = r.spdata;
  assign pc_load_o = r.pcld;
  assign pc_data_o = r.pcdata;
  assign handler_mode_o = ~r.thread;
endmodule

// file: dv/eerc_core_props.sv
// concurrent checks on the exception controller ports
`timescale 1ns/1ns
module eerc_core_props (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus ack
  input wire logic mem_req_o, // frame request
  input wire logic mem_we_o, // frame write
  input wire logic [31:0] mem_addr_o, // frame address
  input wire logic [2:0] mem_idx_o, // frame word
  input wire logic mem_ack_i, // frame done
  input wire logic [31:0] mem_rdata_i, // frame read data
  input wire logic vec_req_o, // vector request
  input wire logic branch_o, // branch pulse
  input wire logic lr_we_o, // token write
  input wire logic [31:0] lr_data_o, // token
  input wire logic sp_we_o, // sp write
  input wire logic [31:0] sp_data_o, // new sp
  input wire logic pc_load_o, // pc restore
  input wire logic [31:0] pc_data_o, // restored pc
  input wire logic handler_mode_o // handler mode
);
  logic [31:0] pc6_reg;
  // return address read while unstacking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc6_reg <= 32'h0;
    end else if (mem_req_o && mem_ack_i && !mem_we_o && mem_idx_o == 3'h6) begin
      pc6_reg <= mem_rdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_word_done; mem_req_o && mem_ack_i; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_last_read; s_word_done ##0 (!mem_we_o && mem_idx_o == 3'h7); endsequence
  property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse; endproperty
  property p_frame_step; s_word_done ##0 (mem_idx_o != 3'h7) |=> mem_req_o
    && mem_idx_o == $past(mem_idx_o) + 3'h1 && mem_addr_o == $past(mem_addr_o) + 32'h4;
  endproperty
  property p_req_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_idx_o)
    && $stable(mem_addr_o) && $stable(mem_we_o);
  endproperty
  property p_push_sp; s_word_done ##0 (mem_we_o && mem_idx_o == 3'h7)
    |=> sp_we_o && sp_data_o == $past(mem_addr_o) - 32'h1c;
  endproperty
  property p_vec_start; $rose(mem_req_o) && mem_we_o |-> vec_req_o && mem_idx_o == 3'h0;
  endproperty
  property p_token; lr_we_o |-> branch_o && lr_data_o[31:4] == 28'hfffffff
    && (lr_data_o[3:0] == 4'h1 || lr_data_o[3:0] == 4'h9 || lr_data_o[3:0] == 4'hd);
  endproperty
  property p_mode; branch_o |=> handler_mode_o; endproperty
  property p_pop; s_last_read |=> pc_load_o && sp_we_o && pc_data_o == pc6_reg
    && sp_data_o == $past(mem_addr_o) + ($past(mem_rdata_i[9]) ? 32'h8 : 32'h4);
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not a single pulse");
  a_frame_step: assert property (p_frame_step) else $error("frame word order broken");
  a_req_hold: assert property (p_req_hold) else $error("frame request changed early");
  a_push_sp: assert property (p_push_sp) else $error("sp not frame base");
  a_vec_start: assert property (p_vec_start) else $error("vector fetch not parallel");
  a_token: assert property (p_token) else $error("bad return token");
  a_mode: assert property (p_mode) else $error("no handler mode after branch");
  a_pop: assert property (p_pop) else $error("pop restore wrong");
endmodule

// file: dv/eerc_core_far.sv
// far-side model: frame memory and vector table responder
`timescale 1ns/1ns
module eerc_core_far (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic slow_i, // 1 stretches answers
  input wire logic mem_req_i, // frame request
  input wire logic mem_we_i, // frame write
  input wire logic [2:0] mem_idx_i, // frame word
  input wire logic [31:0] mem_wdata_i, // frame write data
  output logic mem_ack_o, // frame done
  output logic mem_err_o, // never raised
  output logic [31:0] mem_rdata_o, // frame read data
  input wire logic vec_req_i, // vector request
  input wire logic [31:0] vec_addr_i, // vector address
  output logic vec_ack_o, // vector done
  output logic vec_err_o, // never raised
  output logic [31:0] vec_data_o // handler address
);
  logic [31:0] frame [8];
  logic [1:0] mcnt;
  logic [1:0] vcnt;
  assign mem_err_o = 1'b0;
  assign vec_err_o = 1'b0;
  // frame words: at once or after three waits; idle data toggles
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      mcnt <= 2'h0;
      mem_rdata_o <= 32'h0;
    end else if (mem_req_i && !mem_ack_o) begin
      mcnt <= mcnt + 2'h1;
      if (mcnt == (slow_i ? 2'h3 : 2'h0)) begin
        mcnt <= 2'h0;
        mem_ack_o <= 1'b1;
        mem_rdata_o <= frame[mem_idx_i];
        if (mem_we_i) frame[mem_idx_i] <= mem_wdata_i;
      end
    end
  end
  // vector table: handler is vector address plus offset
  always @(posedge clk_i) begin
    vec_ack_o <= 1'b0;
    vec_data_o <= ~vec_data_o;
    if (rst_i) begin
      vcnt <= 2'h0;
      vec_data_o <= 32'h0;
    end else if (vec_req_i && !vec_ack_o) begin
      vcnt <= vcnt + 2'h1;
      if (vcnt == (slow_i ? 2'h3 : 2'h0)) begin
        vcnt <= 2'h0;
        vec_ack_o <= 1'b1;
        vec_data_o <= vec_addr_i + 32'h1001;
      end
    end
  end
endmodule

// file: dv/eerc_core_tb.sv
// self-checking testbench for the exception controller
`timescale 1ns/1ns
`include "eerc_params.svh"
module eerc_core_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ret = 1'b0, fx = 1'b0, nmi = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00, irq = 8'h00;
  logic [5:0] err = 6'h00;
  logic [31:0] wdat = 32'h0, rval = 32'h0, npc = 32'habc, main_stack_pointer = 32'h20000104;
  logic [31:0] process_stack_pointer = 32'h20000804, q, br, lr, sp, pc, a0;
  logic [31:0] wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, vec_addr_o, vec_data_i;
  logic [31:0] branch_addr_o, lr_data_o, sp_data_o, pc_data_o;
  logic [2:0] mem_idx_o;
  logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, mem_err_i, vec_req_o, vec_ack_i, vec_err_i;
  logic branch_o, lr_we_o, sp_we_o, sp_psp_o, pc_load_o, handler_mode_o, spp, up = 1'b0;
  int nbr, npop, nwr, nrd, mismatches, n_tests;
  always #20 clk_i = ~clk_i;
  eerc_core eerc_core_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .irq_i(irq),
    .nmi_i(nmi), .ibus_err_i(err[0]), .dbus_err_i(err[1]), .undef_i(err[2]),
    .inv_state_i(err[3]), .xn_exec_i(err[4]), .prot_viol_i(err[5]), .next_pc_i(npc),
    .msp_i(main_stack_pointer), .psp_i(process_stack_pointer), .use_psp_i(up), .first_exec_i(fx), .ret_i(ret),
    .ret_val_i(rval), .mem_req_o, .mem_we_o, .mem_addr_o, .mem_idx_o, .mem_wdata_o,
    .mem_ack_i, .mem_err_i, .mem_rdata_i, .vec_req_o, .vec_addr_o, .vec_ack_i, .vec_err_i,
    .vec_data_i, .branch_o, .branch_addr_o, .lr_we_o, .lr_data_o, .sp_we_o, .sp_psp_o,
    .sp_data_o, .pc_load_o, .pc_data_o, .handler_mode_o);
  eerc_core_far eerc_core_far_i (.clk_i, .rst_i, .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_idx_i(mem_idx_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_err_o(mem_err_i),
    .mem_rdata_o(mem_rdata_i), .vec_req_i(vec_req_o), .vec_addr_i(vec_addr_o),
    .vec_ack_o(vec_ack_i), .vec_err_o(vec_err_i), .vec_data_o(vec_data_i));
  // watch branches, restores and frame traffic
  always @(posedge clk_i) begin
    if (branch_o) br <= branch_addr_o;
    if (branch_o) nbr <= nbr + 1;
    if (lr_we_o) lr <= lr_data_o;
    if (sp_we_o) sp <= sp_data_o;
    if (sp_we_o) spp <= sp_psp_o;
    if (pc_load_o) pc <= pc_data_o;
    if (pc_load_o) npop <= npop + 1;
    if (mem_req_o && mem_ack_i) nwr <= nwr + int'(mem_we_o);
    if (mem_req_o && mem_ack_i) nrd <= nrd + int'(!mem_we_o);
    if (mem_req_o && mem_ack_i && mem_idx_o == 3'h0) a0 <= mem_addr_o;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_br(input int b);
    while (nbr == b) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic fire_ret(input logic [31:0] v);
    @(posedge clk_i);
    ret <= 1'b1;
    rval <= v;
    @(posedge clk_i);
    ret <= 1'b0;
  endtask
  task automatic ret_to(input logic [31:0] v);
    int c;
    c = nbr + npop;
    fire_ret(v);
    while (nbr + npop == c) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic go();
    @(posedge clk_i);
    fx <= 1'b1;
    @(posedge clk_i);
    fx <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic pin(input logic [7:0] m);
    @(posedge clk_i);
    irq <= m;
    repeat (4) @(posedge clk_i);
    irq <= 8'h00;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rc(8'h00, `EERC_CTRL_RST);
    rc(8'h04, 32'h0);
    wb(1'b1, 8'h00, 32'hffffffff);
    rc(8'h00, `EERC_CTRL_IMPL);
    wb(1'b1, 8'h04, 32'hffffffff);
    rc(8'h04, `EERC_PRIO_IMPL);
    rc(8'h3c, 32'h0);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h00, 32'h10);
  endtask
  task automatic t_entry();
    int b, w;
    b = nbr;
    w = nwr;
    pin(8'h01);
    wait_br(b);
    chk(nwr - w, 8);
    chk(a0, 32'h200000e0);
    chk(sp, 32'h200000e0);
    chk(lr, 32'hfffffff9);
    chk(br, 32'h1041);
    go();
    wb(1'b0, 8'h0c, 32'h0);
    chk(q & 32'h7ff, 32'h8);
    rc(8'h08, 32'h0);
  endtask
  task automatic t_chain();
    int b, r;
    b = nbr;
    r = nrd;
    pin(8'h02);
    repeat (30) @(posedge clk_i);
    chk(nbr - b, 0);
    rc(8'h08, 32'h10);
    ret_to(32'hfffffff9);
    chk(nrd - r, 0);
    chk(br, 32'h1045);
    go();
  endtask
  task automatic t_fault();
    int b;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      err <= 6'h01 << i;
      @(posedge clk_i);
      err <= 6'h00;
      rc(8'h08, 32'h4);
      ret_to(32'hfffffff9);
      chk(br, 32'h1019);
      go();
    end
    b = nbr + npop;
    fire_ret(32'hfffffff5);
    repeat (20) @(posedge clk_i);
    chk(nbr + npop - b, 0);
    rc(8'h08, 32'h4);
    ret_to(32'hfffffff9);
    go();
    b = nrd;
    ret_to(32'hfffffffd);
    chk(a0, process_stack_pointer);
    chk(nrd - b, 8);
    chk(pc, npc);
    chk(sp, 32'h20000828);
    chk(32'(spp), 32'h1);
    chk(32'(handler_mode_o), 32'h0);
  endtask
  task automatic t_late();
    int b, w;
    wb(1'b1, 8'h00, 32'h113);
    wb(1'b1, 8'h04, 32'h40);
    wb(1'b1, 8'h08, 32'h30);
    b = nbr;
    repeat (20) @(posedge clk_i);
    chk(nbr - b, 0);
    rc(8'h08, 32'h30);
    slow <= 1'b1;
    up <= 1'b1;
    w = nwr;
    wb(1'b1, 8'h00, 32'h13);
    nmi <= 1'b1;
    wait_br(b);
    nmi <= 1'b0;
    chk(br, 32'h1009);
    chk(lr, 32'hfffffffd);
    chk(nwr - w, 8);
    rc(8'h08, 32'h31);
    go();
    ret_to(32'hfffffff9);
    chk(br, 32'h1049);
    go();
    ret_to(32'hfffffff9);
    chk(br, 32'h1045);
    go();
    ret_to(32'hfffffff9);
    chk(sp, 32'h20000128);
    chk({30'h0, spp, handler_mode_o}, 32'h0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_entry();
    t_chain();
    t_fault();
    t_late();
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
endmodule
bind eerc_core eerc_core_props eerc_core_props_i (.*);
